/* File: rtl/ccp_policy.sv */
/*
  ccp_policy: charge-control policy deciding requested current and voltage,
  precharge, end of charge, full/empty flags and the peak temperature record.
  assumes measurements come from logic on clk with a one-cycle meas_valid
  pulse per measurement period; settings are static configuration ports.
*/
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - normal charging requests stored full charge current, shown on output
// - trickle current requested while full charge is halted by heat
// - charging above hot limit: trickle current, complete voltage
// - charging below cold limit: trickle current, complete voltage
// - discharging above discharge hot limit: trickle current, complete voltage
// - normal charging requests stored normal charge voltage
// - after charge complete, request the complete charge voltage
// - full flag clears only below clear level; stops taper monitoring
// - empty flag holds until capacity rises above clear level
// - thermal end of charge loads SOC with stored value
// - thermal end when rise between samples reaches stored minimum
// - voltage-drop end needs drop and current at least stored minimums
// - overcharge end considered only when rate within ceiling
// - reported SOC clamped to stored ceiling
// - peak temperature record keeps largest of both sensors
// - full-charge end ignored until holdoff minutes after charge start
// - end-detect samples separated by the sample interval
// - precharge when temperature below precharge temperature limit
// - precharge when pack voltage below precharge voltage limit
// - precharge requests nominal current limited by ceiling
// - charge alarm clears when pack voltage meets clear voltage
// - SOC error term clamped to zero within clamp range
// - SOC at forced end level forces end of charge
module ccp_policy import ccp_pkg::*; #(
    parameter logic [CCP_TICK_W-1:0] MINUTE_CYCLES = CCP_MINUTE_CYC_FULL[CCP_TICK_W-1:0]
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // measurements
    input wire logic meas_valid,
    input wire logic charging,
    input wire logic discharging,
    input wire logic [15:0] temp_int,
    input wire logic [15:0] temp_ext,
    input wire logic [15:0] pack_voltage,
    input wire logic [15:0] pack_current,
    input wire logic [7:0] charge_rate,
    input wire logic [7:0] soc_in,
    input wire logic [15:0] soc_error_in,
    // stored settings
    input wire logic [15:0] full_charge_current,
    input wire logic [15:0] trickle_current,
    input wire logic [15:0] charge_hot_limit,
    input wire logic [15:0] charge_cold_limit,
    input wire logic [15:0] discharge_hot_limit,
    input wire logic [15:0] normal_charge_voltage,
    input wire logic [15:0] complete_charge_voltage,
    input wire logic [7:0] full_flag_clear_level,
    input wire logic [7:0] empty_flag_clear_level,
    input wire logic [7:0] soc_after_thermal_end,
    input wire logic [7:0] thermal_end_min_rise,
    input wire logic [7:0] voltage_drop_end_min,
    input wire logic [7:0] overcharge_rate_ceiling,
    input wire logic [15:0] voltage_drop_min_current,
    input wire logic [7:0] soc_ceiling,
    input wire logic [7:0] end_detect_holdoff,
    input wire logic [7:0] end_detect_sample_interval,
    input wire logic [15:0] precharge_nominal_current,
    input wire logic [15:0] precharge_current_ceiling,
    input wire logic [15:0] precharge_temperature_limit,
    input wire logic [15:0] precharge_voltage_limit,
    input wire logic [15:0] charge_alarm_clear_voltage,
    input wire logic [7:0] soc_error_clamp_range,
    input wire logic [7:0] soc_forced_end_level,
    // events and status
    input wire logic empty_set,
    input wire logic alarm_set,
    // requests and state
    output logic [15:0] req_current,
    output logic [15:0] req_voltage,
    output logic precharge,
    output logic end_of_charge,
    output logic thermal_end,
    output logic full_flag,
    output logic empty_flag,
    output logic charge_alarm,
    output logic [7:0] soc_out,
    output logic [15:0] soc_error_out,
    output logic [15:0] peak_temperature_record
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ccp_max16(input logic [15:0] a, input logic [15:0] b);
        ccp_max16 = (a > b) ? a : b;
    endfunction : ccp_max16
    function automatic logic [7:0] ccp_min8(input logic [7:0] a, input logic [7:0] b);
        ccp_min8 = (a < b) ? a : b;
    endfunction : ccp_min8
    ////////////////////////////////////////////////////////////////////////////
    logic minute_tick;
    ccp_ticker #(.PERIOD(MINUTE_CYCLES)) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(minute_tick)
    );
    ////////////////////////////////////////////////////////////////////////////
    ccp_state_e state_q, state_d;
    logic [7:0] hold_q, hold_d;
    logic [7:0] samp_q, samp_d;
    logic [15:0] last_t_q, last_t_d;
    logic [15:0] last_v_q, last_v_d;
    logic eoc_q, eoc_d;
    logic therm_q, therm_d;
    logic full_q, full_d;
    logic empty_q, empty_d;
    logic alarm_q, alarm_d;
    logic pre_q, pre_d;
    logic [15:0] cur_q, cur_d;
    logic [15:0] volt_q, volt_d;
    logic [7:0] soc_q, soc_d;
    logic [15:0] err_q, err_d;
    logic [15:0] peak_q, peak_d;
    logic [15:0] temp_now;
    logic sample_now, dt_hit, dv_hit, soc_hit, rate_ok, chg_hot, chg_cold, dis_hot;
    always_comb begin
        temp_now = ccp_max16(temp_int, temp_ext);
        sample_now = meas_valid && (samp_q == 8'h00);
        dt_hit = (temp_now >= last_t_q) && ((temp_now - last_t_q) >= {8'h00, thermal_end_min_rise});
        dv_hit = (last_v_q >= pack_voltage) && ((last_v_q - pack_voltage) >= {8'h00, voltage_drop_end_min})
                 && (pack_current >= voltage_drop_min_current);
        rate_ok = (charge_rate <= overcharge_rate_ceiling);
        soc_hit = (soc_in >= soc_forced_end_level);
        chg_hot = charging && (temp_now > charge_hot_limit);
        chg_cold = charging && (temp_now < charge_cold_limit);
        dis_hot = discharging && (temp_now > discharge_hot_limit);
    end
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        samp_d = samp_q;
        last_t_d = last_t_q;
        last_v_d = last_v_q;
        eoc_d = eoc_q;
        therm_d = 1'b0;
        full_d = full_q;
        empty_d = empty_q;
        alarm_d = alarm_q;
        pre_d = pre_q;
        cur_d = cur_q;
        volt_d = volt_q;
        soc_d = soc_q;
        err_d = err_q;
        peak_d = peak_q;
        // clear first, so a set later in the cycle wins
        if (meas_valid && (soc_in < full_flag_clear_level)) begin
            full_d = 1'b0;
        end
        if (!charging) begin
            state_d = CCP_IDLE;
            eoc_d = 1'b0;
        end else begin
            case (state_q)
                CCP_IDLE: begin
                    state_d = CCP_HOLD;
                    hold_d = end_detect_holdoff;
                    samp_d = 8'h00;
                end
                CCP_HOLD: begin
                    if (hold_q == 8'h00) begin
                        state_d = CCP_WATCH;
                    end else if (minute_tick) begin
                        hold_d = hold_q - 8'h01;
                    end
                end
                CCP_WATCH: begin
                    if (meas_valid) begin
                        samp_d = (samp_q == 8'h00) ? end_detect_sample_interval : samp_q - 8'h01;
                    end
                    if (sample_now) begin
                        if (!full_q && (dt_hit || (rate_ok && (dv_hit || soc_hit)))) begin
                            state_d = CCP_DONE;
                            eoc_d = 1'b1;
                            full_d = 1'b1;
                            therm_d = dt_hit;
                        end
                    end
                end
                CCP_DONE: begin
                    eoc_d = 1'b1;
                end
                default: begin
                    state_d = CCP_IDLE;
                end
            endcase
        end
        if (meas_valid) begin
            peak_d = ccp_max16(peak_q, temp_now);
            pre_d = charging && ((temp_now < precharge_temperature_limit) || (pack_voltage < precharge_voltage_limit));
            if (sample_now || (state_q != CCP_WATCH)) begin
                last_t_d = temp_now;
                last_v_d = pack_voltage;
            end
            if (soc_in > empty_flag_clear_level) begin
                empty_d = 1'b0;
            end
            if (pack_voltage >= charge_alarm_clear_voltage) begin
                alarm_d = 1'b0;
            end
            soc_d = ccp_min8(soc_in, soc_ceiling);
            err_d = (soc_in >= soc_error_clamp_range) ? 16'h0000 : soc_error_in;
        end
        // set wins over clear
        if (empty_set) begin
            empty_d = 1'b1;
        end
        if (alarm_set) begin
            alarm_d = 1'b1;
        end
        if (therm_d) begin
            soc_d = ccp_min8(soc_after_thermal_end, soc_ceiling);
        end
        if (chg_hot || chg_cold || dis_hot || eoc_d) begin
            cur_d = trickle_current;
            volt_d = complete_charge_voltage;
        end else if (pre_d) begin
            cur_d = (precharge_nominal_current > precharge_current_ceiling) ?
                    precharge_current_ceiling : precharge_nominal_current;
            volt_d = normal_charge_voltage;
        end else begin
            cur_d = full_charge_current;
            volt_d = normal_charge_voltage;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= CCP_IDLE;
            hold_q <= CCP_HOLDOFF_RST;
            samp_q <= 8'h00;
            last_t_q <= 16'h0000;
            last_v_q <= 16'h0000;
            eoc_q <= 1'b0;
            therm_q <= 1'b0;
            full_q <= 1'b0;
            empty_q <= 1'b0;
            alarm_q <= 1'b0;
            pre_q <= 1'b0;
            cur_q <= CCP_FULL_CURR_RST;
            volt_q <= CCP_NORM_VOLT_RST;
            soc_q <= 8'h00;
            err_q <= 16'h0000;
            peak_q <= CCP_PEAK_T_RST;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            samp_q <= samp_d;
            last_t_q <= last_t_d;
            last_v_q <= last_v_d;
            eoc_q <= eoc_d;
            therm_q <= therm_d;
            full_q <= full_d;
            empty_q <= empty_d;
            alarm_q <= alarm_d;
            pre_q <= pre_d;
            cur_q <= cur_d;
            volt_q <= volt_d;
            soc_q <= soc_d;
            err_q <= err_d;
            peak_q <= peak_d;
        end
    end
    assign req_current = cur_q;
    assign req_voltage = volt_q;
    assign precharge = pre_q;
    assign end_of_charge = eoc_q;
    assign thermal_end = therm_q;
    assign full_flag = full_q;
    assign empty_flag = empty_q;
    assign charge_alarm = alarm_q;
    assign soc_out = soc_q;
    assign soc_error_out = err_q;
    assign peak_temperature_record = peak_q;
    ////////////////////////////////////////////////////////////////////////////
    property p_hot_trickle;
        @(posedge clk) disable iff (rst) chg_hot |=> (req_current == $past(trickle_current));
    endproperty
    a_hot_trickle: assert property (p_hot_trickle) else $error("hot charge not trickle");
    property p_cold_off;
        @(posedge clk) disable iff (rst) chg_cold |=> (req_voltage == $past(complete_charge_voltage));
    endproperty
    a_cold_off: assert property (p_cold_off) else $error("cold charge not off voltage");
    property p_dis_hot;
        @(posedge clk) disable iff (rst) dis_hot |=> (req_current == $past(trickle_current));
    endproperty
    a_dis_hot: assert property (p_dis_hot) else $error("hot discharge not trickle");
    property p_peak;
        @(posedge clk) disable iff (rst) meas_valid |=> (peak_temperature_record >= $past(temp_now));
    endproperty
    a_peak: assert property (p_peak) else $error("peak record missed value");
    property p_soc_ceil;
        @(posedge clk) disable iff (rst) meas_valid ##1 !thermal_end |-> (soc_out <= $past(soc_ceiling));
    endproperty
    a_soc_ceil: assert property (p_soc_ceil) else $error("soc above ceiling");
    property p_holdoff;
        @(posedge clk) disable iff (rst) (state_q == CCP_HOLD) |-> !eoc_d;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("end during holdoff");
    property p_pre_volt;
        @(posedge clk) disable iff (rst) (meas_valid && charging && pack_voltage < precharge_voltage_limit) |=> precharge;
    endproperty
    a_pre_volt: assert property (p_pre_volt) else $error("precharge missed on low voltage");
    property p_pre_lim;
        @(posedge clk) disable iff (rst) precharge && !end_of_charge && !$past(chg_hot || chg_cold || dis_hot)
            |-> (req_current <= $past(precharge_current_ceiling));
    endproperty
    a_pre_lim: assert property (p_pre_lim) else $error("precharge current over ceiling");
    property p_full_hold;
        @(posedge clk) disable iff (rst) (full_flag && !(meas_valid && soc_in < full_flag_clear_level)) |=> full_flag;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full flag dropped early");
    c_eoc: cover property (@(posedge clk) disable iff (rst) $rose(end_of_charge));
    c_therm: cover property (@(posedge clk) disable iff (rst) thermal_end);
    c_pre: cover property (@(posedge clk) disable iff (rst) $rose(precharge));
endmodule : ccp_policy

/* File: rtl/ccp_pkg.sv */
/*
  ccp_pkg: reset values, widths and timing counts of the charge-control policy.
  assumes one 200 MHz clock; measurements arrive already coded in fixed units.
*/
package ccp_pkg;
    // reset values of the stored settings
    localparam logic [15:0] CCP_FULL_CURR_RST = 16'd3500;
    localparam logic [15:0] CCP_TRICKLE_CURR_RST = 16'd100;
    localparam logic [15:0] CCP_CHG_HOT_RST = 16'd800;
    localparam logic [15:0] CCP_CHG_COLD_RST = 16'd200;
    localparam logic [15:0] CCP_NORM_VOLT_RST = 16'hffff;
    localparam logic [15:0] CCP_DONE_VOLT_RST = 16'h0000;
    localparam logic [7:0] CCP_FULL_CLR_RST = 8'd115;
    localparam logic [7:0] CCP_EMPTY_CLR_RST = 8'd13;
    localparam logic [15:0] CCP_DIS_HOT_RST = 16'd800;
    localparam logic [7:0] CCP_SOC_THERM_RST = 8'd95;
    localparam logic [7:0] CCP_DT_MIN_RST = 8'd60;
    localparam logic [7:0] CCP_DV_MIN_RST = 8'd10;
    localparam logic [7:0] CCP_RATE_MAX_RST = 8'd4;
    localparam logic [15:0] CCP_DV_CURR_RST = 16'd1;
    localparam logic [7:0] CCP_SOC_CEIL_RST = 8'd100;
    localparam logic [15:0] CCP_PEAK_T_RST = 16'd750;
    localparam logic [7:0] CCP_HOLDOFF_RST = 8'd5;
    localparam logic [7:0] CCP_SAMPLE_RST = 8'd60;
    localparam logic [15:0] CCP_PRE_CURR_RST = 16'd300;
    localparam logic [15:0] CCP_PRE_MAX_RST = 16'd500;
    localparam logic [15:0] CCP_PRE_T_RST = 16'd250;
    localparam logic [15:0] CCP_PRE_V_RST = 16'd7000;
    localparam logic [15:0] CCP_ALARM_V_RST = 16'd11000;
    localparam logic [7:0] CCP_ERR_RANGE_RST = 8'd120;
    localparam logic [7:0] CCP_SOC_END_RST = 8'd154;
    // time base
    localparam longint CCP_CLK_HZ = 200000000;
    localparam longint CCP_MINUTE_S = 60;
    localparam longint CCP_MINUTE_CYC_FULL = CCP_CLK_HZ * CCP_MINUTE_S;
    // a minute at 200 MHz needs 34 bits; 32 would wrap the count
    localparam int CCP_TICK_W = 34;
    // policy states
    typedef enum logic [1:0] {
        CCP_IDLE = 2'b00,
        CCP_HOLD = 2'b01,
        CCP_WATCH = 2'b11,
        CCP_DONE = 2'b10
    } ccp_state_e;
endpackage : ccp_pkg

/* File: rtl/ccp_ticker.sv */
/*
  ccp_ticker: free-running divider giving one-cycle minute ticks.
  assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
module ccp_ticker import ccp_pkg::*; #(
    parameter logic [CCP_TICK_W-1:0] PERIOD = CCP_MINUTE_CYC_FULL[CCP_TICK_W-1:0]
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // tick out
    output logic tick
);
    localparam logic [CCP_TICK_W-1:0] CNT_ONE = CCP_TICK_W'(1);
    logic [CCP_TICK_W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = (cnt_q >= PERIOD - CNT_ONE) ? '0 : cnt_q + CNT_ONE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = (cnt_q == PERIOD - CNT_ONE);
endmodule : ccp_ticker

/* File: tb/ccp_charger_model.sv */
/*
  ccp_charger_model: charger on the far side of the policy's requests.
  assumes requests are registered on clk; the charger follows them one cycle late.
*/
`timescale 1ns/1ps
module ccp_charger_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests from the policy
    input wire logic [15:0] req_current,
    input wire logic [15:0] req_voltage,
    // what the charger applies
    output logic [15:0] applied_current,
    output logic [15:0] applied_voltage
);
    // a real charger slews; one cycle of lag is the kindest it gets
    always_ff @(posedge clk) begin
        if (rst) begin
            applied_current <= 16'h0000;
            applied_voltage <= 16'h0000;
        end else begin
            applied_current <= req_current;
            applied_voltage <= req_voltage;
        end
    end
endmodule : ccp_charger_model

/* File: tb/tb_top.sv */
/*
  tb_top: self-checking bench for the charge-control policy and a charger model.
  assumes the package and both modules are compiled first; minute shortened to 20 cycles.
*/
`timescale 1ns/1ps
module tb_top import ccp_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, meas_valid = 1'b0, charging = 1'b0;
    logic discharging = 1'b0, empty_set = 1'b0, alarm_set = 1'b0;
    logic [15:0] temp_int = 16'h01f4, temp_ext = 16'h01f4, pack_voltage = 16'h1f40;
    logic [15:0] pack_current = 16'h0064, soc_error_in = 16'h0000;
    logic [7:0] charge_rate = 8'h01, soc_in = 8'h40;
    logic [15:0] full_charge_current = CCP_FULL_CURR_RST, trickle_current = CCP_TRICKLE_CURR_RST;
    logic [15:0] charge_hot_limit = CCP_CHG_HOT_RST, charge_cold_limit = CCP_CHG_COLD_RST;
    logic [15:0] discharge_hot_limit = CCP_DIS_HOT_RST, normal_charge_voltage = CCP_NORM_VOLT_RST;
    logic [15:0] complete_charge_voltage = CCP_DONE_VOLT_RST, voltage_drop_min_current = CCP_DV_CURR_RST;
    logic [15:0] precharge_nominal_current = CCP_PRE_CURR_RST, precharge_current_ceiling = CCP_PRE_MAX_RST;
    logic [15:0] precharge_temperature_limit = CCP_PRE_T_RST, precharge_voltage_limit = CCP_PRE_V_RST;
    logic [15:0] charge_alarm_clear_voltage = CCP_ALARM_V_RST;
    logic [7:0] full_flag_clear_level = CCP_FULL_CLR_RST, empty_flag_clear_level = CCP_EMPTY_CLR_RST;
    logic [7:0] soc_after_thermal_end = CCP_SOC_THERM_RST, thermal_end_min_rise = CCP_DT_MIN_RST;
    logic [7:0] voltage_drop_end_min = CCP_DV_MIN_RST, overcharge_rate_ceiling = CCP_RATE_MAX_RST;
    logic [7:0] soc_ceiling = CCP_SOC_CEIL_RST, end_detect_holdoff = 8'hff;
    logic [7:0] end_detect_sample_interval = 8'h02, soc_error_clamp_range = CCP_ERR_RANGE_RST;
    logic [7:0] soc_forced_end_level = CCP_SOC_END_RST, soc_out;
    logic [15:0] req_current, req_voltage, soc_error_out, peak_temperature_record;
    logic [15:0] applied_current, applied_voltage, t, v;
    logic precharge, end_of_charge, thermal_end, full_flag, empty_flag, charge_alarm;
    int failures = 0, check_count = 0, te_count = 0, i;
    // limit table: internal temp, external temp, expected current and voltage
    logic [15:0] tab_ti [7] = '{16'h0321, 16'h0320, 16'h00c7, 16'h00c8, 16'h00f9, 16'h00fa, 16'h01f4};
    logic [15:0] tab_te [7] = '{16'h01f4, 16'h0320, 16'h00c7, 16'h00c8, 16'h00f9, 16'h00fa, 16'h0321};
    logic [15:0] tab_c [7] = '{16'h0064, 16'h0dac, 16'h0064, 16'h012c, 16'h012c, 16'h0dac, 16'h0064};
    logic [15:0] tab_v [7] = '{16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'hffff, 16'hffff, 16'h0000};

    ccp_policy #(.MINUTE_CYCLES(34'h000000014)) u_ccp_policy (.*);
    ccp_charger_model u_ccp_charger_model (.*);

    always #2.5 clk = ~clk;
    // thermal end must be a single one-cycle pulse
    always @(posedge clk) begin
        if (thermal_end === 1'b1) begin
            te_count++;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one measurement set, answer settled one edge after it is taken
    task meas(input logic [15:0] ti, input logic [15:0] te, input logic [15:0] pv, input logic [7:0] s);
        @(posedge clk);
        temp_int <= ti;
        temp_ext <= te;
        pack_voltage <= pv;
        soc_in <= s;
        meas_valid <= 1'b1;
        @(posedge clk);
        meas_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask : meas
    task pulse(input logic e, input logic a);
        @(posedge clk);
        empty_set <= e;
        alarm_set <= a;
        @(posedge clk);
        empty_set <= 1'b0;
        alarm_set <= 1'b0;
        @(posedge clk);
        #1;
    endtask : pulse
    task tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        #1;
        chk(req_current, 16'h0dac);
        chk(req_voltage, 16'hffff);
        chk(peak_temperature_record, 16'h02ee);
        chk(full_flag, 1'b0);
        chk(empty_flag, 1'b0);
        chk(charge_alarm, 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        charging <= 1'b1;
        for (i = 0; i < 7; i++) begin
            meas(tab_ti[i], tab_te[i], 16'h1f40, 8'h40);
            chk(req_current, tab_c[i]);
            chk(req_voltage, tab_v[i]);
        end
        meas(16'h01f4, 16'h01f4, 16'h1b57, 8'h40);
        chk(precharge, 1'b1);
        chk(req_current, 16'h012c);
        @(posedge clk);
        #1;
        chk(applied_current, 16'h012c);
        meas(16'h01f4, 16'h01f4, 16'h1b58, 8'h40);
        chk(precharge, 1'b0);
        chk(req_current, 16'h0dac);
        @(posedge clk);
        precharge_nominal_current <= 16'h0258;
        meas(16'h01f4, 16'h01f4, 16'h1b57, 8'h40);
        chk(req_current, 16'h01f4);
        @(posedge clk);
        precharge_nominal_current <= 16'h012c;
        meas(16'h0384, 16'h012c, 16'h1f40, 8'h40);
        chk(peak_temperature_record, 16'h0384);
        meas(16'h01f4, 16'h0352, 16'h1f40, 8'h40);
        chk(peak_temperature_record, 16'h0384);
        meas(16'h01f4, 16'h03b6, 16'h1f40, 8'h40);
        chk(peak_temperature_record, 16'h03b6);
        @(posedge clk);
        soc_error_in <= 16'h1234;
        meas(16'h01f4, 16'h01f4, 16'h1f40, 8'h63);
        chk(soc_error_out, 16'h1234);
        chk(soc_out, 8'h63);
        meas(16'h01f4, 16'h01f4, 16'h1f40, 8'h78);
        chk(soc_error_out, 16'h0000);
        chk(soc_out, 8'h64);
        pulse(1'b0, 1'b1);
        chk(charge_alarm, 1'b1);
        meas(16'h01f4, 16'h01f4, 16'h2af7, 8'h0a);
        chk(charge_alarm, 1'b1);
        meas(16'h01f4, 16'h01f4, 16'h2af8, 8'h0a);
        chk(charge_alarm, 1'b0);
        pulse(1'b1, 1'b0);
        chk(empty_flag, 1'b1);
        meas(16'h01f4, 16'h01f4, 16'h1f40, 8'h0d);
        chk(empty_flag, 1'b1);
        meas(16'h01f4, 16'h01f4, 16'h1f40, 8'h0e);
        chk(empty_flag, 1'b0);
        @(posedge clk);
        charging <= 1'b0;
        discharging <= 1'b1;
        meas(16'h0321, 16'h01f4, 16'h1f40, 8'h40);
        chk(req_current, 16'h0064);
        chk(req_voltage, 16'h0000);
        @(posedge clk);
        discharging <= 1'b0;
        end_detect_holdoff <= 8'h05;
        charge_hot_limit <= 16'hffff;
        // thermal session: a rise of 19 per measurement stays under the minimum
        @(posedge clk);
        charging <= 1'b1;
        t = 16'h01cc;
        meas(t, t, 16'h1f40, 8'h40);
        repeat (130) @(posedge clk);
        for (i = 0; i < 9; i++) begin
            t = t + 16'h0013;
            meas(t, t, 16'h1f40, 8'h40);
            chk(end_of_charge, 1'b0);
        end
        for (i = 0; i < 9 && end_of_charge !== 1'b1; i++) begin
            t = t + 16'h0014;
            meas(t, t, 16'h1f40, 8'h40);
        end
        repeat (2) @(posedge clk);
        #1;
        chk(end_of_charge, 1'b1);
        chk(te_count[15:0], 16'h0001);
        chk(soc_out, 8'h5f);
        chk(full_flag, 1'b1);
        chk(req_current, 16'h0064);
        chk(req_voltage, 16'h0000);
        chk(applied_voltage, 16'h0000);
        @(posedge clk);
        charging <= 1'b0;
        meas(t, t, 16'h1f40, 8'h73);
        chk(full_flag, 1'b1);
        meas(t, t, 16'h1f40, 8'h72);
        chk(full_flag, 1'b0);
        // state-of-charge session: holdoff, rate gate, then the forced end
        @(posedge clk);
        charging <= 1'b1;
        for (i = 0; i < 3; i++) begin
            meas(t, t, 16'h1f40, 8'hc8);
            chk(end_of_charge, 1'b0);
        end
        repeat (130) @(posedge clk);
        charge_rate <= 8'h05;
        for (i = 0; i < 6; i++) begin
            meas(t, t, 16'h1f40, 8'h9a);
            chk(end_of_charge, 1'b0);
        end
        @(posedge clk);
        charge_rate <= 8'h04;
        for (i = 0; i < 6; i++) begin
            meas(t, t, 16'h1f40, 8'h99);
            chk(end_of_charge, 1'b0);
        end
        for (i = 0; i < 6 && end_of_charge !== 1'b1; i++) begin
            meas(t, t, 16'h1f40, 8'h9a);
        end
        chk(end_of_charge, 1'b1);
        // voltage-drop session: a fall of 9 per sample stays under the minimum
        @(posedge clk);
        charging <= 1'b0;
        meas(t, t, 16'h1f40, 8'h40);
        @(posedge clk);
        charging <= 1'b1;
        pack_current <= 16'h0001;
        v = 16'h1f40;
        meas(t, t, v, 8'h40);
        repeat (130) @(posedge clk);
        for (i = 0; i < 4; i++) begin
            v = v - 16'h0003;
            meas(t, t, v, 8'h40);
            chk(end_of_charge, 1'b0);
        end
        for (i = 0; i < 6 && end_of_charge !== 1'b1; i++) begin
            v = v - 16'h0004;
            meas(t, t, v, 8'h40);
        end
        chk(end_of_charge, 1'b1);
        chk(te_count[15:0], 16'h0001);
        tally_and_finish;
    end
    // the whole run is under two thousand cycles
    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        tally_and_finish;
    end
endmodule : tb_top
